// file: hdl/tdmp_datapath.sv
// Purpose: serial time-division highway pin logic, tx and rx
// Assumes: config ports are static while the highway runs
// Notes:   tx logic on tx_serial_clock, rx on the selected rx clock
`include "tdmp_cfg.svh"

// Overview of operation
// - pin-17 select 0: shared output pin carries second transmit data.
// - second output drives data only while its enable is 1.
// - pin-17 select 1: shared pin is active-low slot strobe for primary.
// - strobe low exactly on valid primary bit positions, high otherwise.
// - pin-17 select 1 makes the second-output enable ignored.
// - shift out on falling edge; invert bit selects rising edge.
// - pin-21 select 1: receive clocked by transmit clock; else independent.
// - primary output drives data only in its selected slot and only while its enable is 1.
// - pin-17 select 0 with both enables set: same byte on both outputs simultaneously.
// - transmit invert bit inverts every sent bit.
// - transmit in selected slot, bit 0 or bit 7 first per order bit.
// - receive pin select 0 samples the primary receive input.
// - receive invert bit and receive clock edge select apply.
// - capture only in selected receive slot, bit order per order bit.
// - frame-sync pulse of chosen polarity starts the frame count.
module tdmp_datapath
    import tdmp_pkg::*;
#(
    parameter int SLOT_W = `TDMP_SLOT_W
) (
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire logic              tx_serial_clock,
    input  wire logic              rx_serial_clock,
    input  wire logic              frame_sync,
    input  wire logic              rx_data_primary,
    output logic                   tx_data_primary,
    output logic                   tx_data_primary_oe,
    output logic                   tx_data_secondary,
    output logic                   tx_data_secondary_oe,
    input  wire logic              frame_sync_polarity,
    input  wire logic              shared_out_pin_select,
    input  wire logic              primary_out_enable,
    input  wire logic              secondary_out_enable,
    input  wire logic              tx_clock_edge_invert,
    input  wire logic              tx_bit_invert,
    input  wire logic              tx_bit_order,
    input  wire logic [SLOT_W-1:0] tx_slot,
    input  wire logic              shared_in_pin_select,
    input  wire logic              rx_pin_select,
    input  wire logic              rx_bit_invert,
    input  wire logic              rx_clock_edge_invert,
    input  wire logic              rx_bit_order,
    input  wire logic [SLOT_W-1:0] rx_slot,
    input  wire tdmp_byte_t        tx_byte,
    input  wire logic              tx_byte_valid,
    output logic                   tx_byte_ready,
    output tdmp_byte_t             rx_byte,
    output logic                   rx_byte_valid,
    input  wire logic              rx_byte_ready,
    output logic                   rx_overrun
);
    localparam int CW  = SLOT_W + 3;
    localparam int TXW = SLOT_W + 7;
    localparam int RXW = SLOT_W + 6;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic slot_hit(input logic [CW-1:0] cnt, input logic [SLOT_W-1:0] slot);
        slot_hit = (cnt[CW-1:3] == slot);
    endfunction

    function automatic logic [2:0] bit_pos(input logic [2:0] idx, input logic order);
        bit_pos = order ? (3'h7 - idx) : idx;
    endfunction

    // {primary data, primary oe, shared data, shared oe}
    function automatic tdmp_pins_t pin_drive(input logic [CW-1:0] cnt, input tdmp_byte_t byt,
                                             input logic framed, input logic [TXW-1:0] cfg);
        logic hit;
        logic dat;
        logic pri;
        hit = framed & slot_hit(cnt, cfg[SLOT_W-1:0]);
        dat = byt[bit_pos(cnt[2:0], cfg[`TDMP_TXC_ORDER])] ^ cfg[`TDMP_TXC_INV];
        pri = hit & cfg[`TDMP_TXC_PRI_EN];
        if (cfg[`TDMP_TXC_P17]) begin
            pin_drive = {dat, pri, ~pri, 1'b1};
        end else begin
            pin_drive = {dat, pri, dat, hit & cfg[`TDMP_TXC_SEC_EN]};
        end
    endfunction

    // ****************************************************************
    // system side: tx buffer and hand-off word
    // ****************************************************************
    tdmp_byte_t      txb_data;
    logic            txb_valid;
    logic            tx_req_q;
    logic [1:0]      tx_ack_s_q;
    tdmp_byte_t      tx_hold_q;
    logic            tx_ack_q;
    wire             tx_hold_free = (tx_req_q == tx_ack_s_q[1]);

    tdmp_buf2 #(.W(`TDMP_BYTE_W)) u_txbuf (
        .clock     (clock),
        .resetn    (resetn),
        .in_data   (tx_byte),
        .in_valid  (tx_byte_valid),
        .in_ready  (tx_byte_ready),
        .out_data  (txb_data),
        .out_valid (txb_valid),
        .out_ready (tx_hold_free)
    );

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tx_req_q   <= 1'b0;
            tx_ack_s_q <= 2'h0;
            tx_hold_q  <= `TDMP_IDLE_BYTE;
        end else begin
            tx_ack_s_q <= {tx_ack_s_q[0], tx_ack_q};
            if (tx_hold_free && txb_valid) begin
                tx_hold_q <= txb_data;
                tx_req_q  <= ~tx_req_q;
            end
        end
    end

    // ****************************************************************
    // tx link domain
    // ****************************************************************
    logic [1:0]      tx_rst_q;
    logic [TXW-1:0]  txc_s1_q;
    logic [TXW-1:0]  txc_q;
    logic [1:0]      tx_req_s_q;
    logic            tx_fr_prev_q;
    logic            tx_framed_q;
    logic [CW-1:0]   tx_cnt_q;
    tdmp_byte_t      tx_sh_q;
    tdmp_pins_t      pins_p_q;
    tdmp_pins_t      pins_n_q;
    wire             tx_rstn = tx_rst_q[1];
    wire [TXW-1:0]   txc_in  = {frame_sync_polarity, shared_out_pin_select, primary_out_enable,
                                secondary_out_enable, tx_clock_edge_invert, tx_bit_invert,
                                tx_bit_order, tx_slot};
    wire             tx_fr_lvl   = frame_sync ~^ txc_q[`TDMP_TXC_FRPOL];
    wire             tx_fr_start = tx_fr_lvl & ~tx_fr_prev_q;
    wire [CW-1:0]    tx_cnt_d    = tx_fr_start ? '0 : tx_cnt_q + 1'b1;
    wire             tx_framed_d = tx_framed_q | tx_fr_start;
    wire             tx_have     = (tx_req_s_q[1] != tx_ack_q);
    wire             tx_load     = tx_framed_d & slot_hit(tx_cnt_d, txc_q[SLOT_W-1:0])
                                   & (tx_cnt_d[2:0] == 3'h0);
    wire tdmp_byte_t tx_sh_d     = !tx_load ? tx_sh_q : (tx_have ? tx_hold_q : `TDMP_IDLE_BYTE);

    always_ff @(posedge tx_serial_clock or negedge resetn) begin
        if (!resetn) begin
            tx_rst_q <= 2'h0;
        end else begin
            tx_rst_q <= {tx_rst_q[0], 1'b1};
        end
    end

    always_ff @(posedge tx_serial_clock or negedge tx_rstn) begin
        if (!tx_rstn) begin
            txc_s1_q     <= '0;
            txc_q        <= '0;
            tx_req_s_q   <= 2'h0;
            tx_ack_q     <= 1'b0;
            tx_fr_prev_q <= 1'b1;
            tx_framed_q  <= 1'b0;
            tx_cnt_q     <= '0;
            tx_sh_q      <= `TDMP_IDLE_BYTE;
        end else begin
            txc_s1_q     <= txc_in;
            txc_q        <= txc_s1_q;
            tx_req_s_q   <= {tx_req_s_q[0], tx_req_q};
            tx_ack_q     <= tx_ack_q ^ (tx_load & tx_have);
            tx_fr_prev_q <= tx_fr_lvl;
            tx_framed_q  <= tx_framed_d;
            tx_cnt_q     <= tx_cnt_d;
            tx_sh_q      <= tx_sh_d;
        end
    end

    // rising-edge launch: drive for the bit that starts at this edge
    always_ff @(posedge tx_serial_clock or negedge tx_rstn) begin
        if (!tx_rstn) begin
            pins_p_q <= 4'h0;
        end else begin
            pins_p_q <= pin_drive(tx_cnt_d, tx_sh_d, tx_framed_d, txc_q);
        end
    end

    // falling-edge launch, the reset default edge
    always_ff @(negedge tx_serial_clock or negedge tx_rstn) begin
        if (!tx_rstn) begin
            pins_n_q <= 4'h0;
        end else begin
            pins_n_q <= pin_drive(tx_cnt_q, tx_sh_q, tx_framed_q, txc_q);
        end
    end

    // one shifted byte feeds both outputs under pin-17 select 0; oe low means high impedance
    wire tdmp_pins_t pins_sel = txc_q[`TDMP_TXC_EDGE] ? pins_p_q : pins_n_q;
    assign tx_data_primary      = pins_sel[3];
    assign tx_data_primary_oe   = pins_sel[2];
    assign tx_data_secondary    = pins_sel[1];
    assign tx_data_secondary_oe = pins_sel[0];

    // ****************************************************************
    // rx link domain
    // ****************************************************************
    // pin 21 is the rx clock unless it is rx data, then the tx clock serves
    wire             rx_clk = shared_in_pin_select ? tx_serial_clock : rx_serial_clock;
    logic [1:0]      rx_rst_q;
    logic [RXW-1:0]  rxc_s1_q;
    logic [RXW-1:0]  rxc_q;
    logic            rx_fr_prev_q;
    logic            rx_framed_q;
    logic [CW-1:0]   rx_cnt_q;
    logic            rx_neg_q;
    tdmp_byte_t      rx_sh_q;
    tdmp_byte_t      rx_word_q;
    logic            rx_tog_q;
    wire             rx_rstn = rx_rst_q[1];
    wire [RXW-1:0]   rxc_in  = {frame_sync_polarity, shared_in_pin_select, rx_pin_select,
                                rx_clock_edge_invert, rx_bit_invert, rx_bit_order, rx_slot};
    wire             rx_pin  = (rxc_q[`TDMP_RXC_P21] & rxc_q[`TDMP_RXC_PINSEL])
                               ? rx_serial_clock : rx_data_primary;
    wire             rx_fr_lvl   = frame_sync ~^ rxc_q[`TDMP_RXC_FRPOL];
    wire             rx_fr_start = rx_fr_lvl & ~rx_fr_prev_q;
    wire [CW-1:0]    rx_cnt_d    = rx_fr_start ? '0 : rx_cnt_q + 1'b1;
    wire             rx_framed_d = rx_framed_q | rx_fr_start;
    wire             rx_bit      = (rxc_q[`TDMP_RXC_EDGE] ? rx_pin : rx_neg_q)
                                   ^ rxc_q[`TDMP_RXC_INV];
    wire             rx_in_slot  = rx_framed_d & slot_hit(rx_cnt_d, rxc_q[SLOT_W-1:0]);
    wire [2:0]       rx_pos      = bit_pos(rx_cnt_d[2:0], rxc_q[`TDMP_RXC_ORDER]);
    wire             rx_last     = rx_in_slot & (rx_cnt_d[2:0] == 3'h7);
    tdmp_byte_t      rx_sh_d;

    always_comb begin
        rx_sh_d = rx_sh_q;
        if (rx_in_slot) begin
            rx_sh_d[rx_pos] = rx_bit;
        end
    end

    always_ff @(posedge rx_clk or negedge resetn) begin
        if (!resetn) begin
            rx_rst_q <= 2'h0;
        end else begin
            rx_rst_q <= {rx_rst_q[0], 1'b1};
        end
    end

    always_ff @(negedge rx_clk or negedge rx_rstn) begin
        if (!rx_rstn) begin
            rx_neg_q <= 1'b0;
        end else begin
            rx_neg_q <= rx_pin;
        end
    end

    always_ff @(posedge rx_clk or negedge rx_rstn) begin
        if (!rx_rstn) begin
            rxc_s1_q     <= '0;
            rxc_q        <= '0;
            rx_fr_prev_q <= 1'b1;
            rx_framed_q  <= 1'b0;
            rx_cnt_q     <= '0;
            rx_sh_q      <= '0;
            rx_word_q    <= '0;
            rx_tog_q     <= 1'b0;
        end else begin
            rxc_s1_q     <= rxc_in;
            rxc_q        <= rxc_s1_q;
            rx_fr_prev_q <= rx_fr_lvl;
            rx_framed_q  <= rx_framed_d;
            rx_cnt_q     <= rx_cnt_d;
            rx_sh_q      <= rx_sh_d;
            if (rx_last) begin
                rx_word_q <= rx_sh_d;
                rx_tog_q  <= ~rx_tog_q;
            end
        end
    end

    // ****************************************************************
    // system side: rx event crossing and buffer
    // ****************************************************************
    logic [2:0]      rx_tog_s_q;
    logic            rx_push_q;
    tdmp_byte_t      rx_push_data_q;
    logic            rxb_in_ready;
    logic            rx_overrun_q;
    wire             rx_event = rx_tog_s_q[2] ^ rx_tog_s_q[1];

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rx_tog_s_q     <= 3'h0;
            rx_push_q      <= 1'b0;
            rx_push_data_q <= '0;
            rx_overrun_q   <= 1'b0;
        end else begin
            rx_tog_s_q   <= {rx_tog_s_q[1:0], rx_tog_q};
            rx_push_q    <= rx_event | (rx_push_q & ~rxb_in_ready);
            rx_overrun_q <= rx_event & rx_push_q & ~rxb_in_ready;
            if (rx_event) begin
                rx_push_data_q <= rx_word_q;
            end
        end
    end

    tdmp_buf2 #(.W(`TDMP_BYTE_W)) u_rxbuf (
        .clock     (clock),
        .resetn    (resetn),
        .in_data   (rx_push_data_q),
        .in_valid  (rx_push_q),
        .in_ready  (rxb_in_ready),
        .out_data  (rx_byte),
        .out_valid (rx_byte_valid),
        .out_ready (rx_byte_ready)
    );

    assign rx_overrun = rx_overrun_q;
endmodule

// file: hdl/tdmp_cfg.svh
// Purpose: constants of the serial highway pin datapath
// Assumes: included by the package and by the design modules
// Notes:   widths and tx/rx config vector field positions
`ifndef TDMP_CFG_SVH
`define TDMP_CFG_SVH

// ****************************************************************
// data and slot sizing
// ****************************************************************
`define TDMP_BYTE_W        8
`define TDMP_SLOT_W        7
`define TDMP_IDLE_BYTE     8'hFF
`define TDMP_SYNC_STAGES   2

// ****************************************************************
// tx config vector fields (slot field sits in the low bits)
// ****************************************************************
`define TDMP_TXC_ORDER     (`TDMP_SLOT_W + 0)
`define TDMP_TXC_INV       (`TDMP_SLOT_W + 1)
`define TDMP_TXC_EDGE      (`TDMP_SLOT_W + 2)
`define TDMP_TXC_SEC_EN    (`TDMP_SLOT_W + 3)
`define TDMP_TXC_PRI_EN    (`TDMP_SLOT_W + 4)
`define TDMP_TXC_P17       (`TDMP_SLOT_W + 5)
`define TDMP_TXC_FRPOL     (`TDMP_SLOT_W + 6)
`define TDMP_TXC_W         (`TDMP_SLOT_W + 7)

// ****************************************************************
// rx config vector fields
// ****************************************************************
`define TDMP_RXC_ORDER     (`TDMP_SLOT_W + 0)
`define TDMP_RXC_INV       (`TDMP_SLOT_W + 1)
`define TDMP_RXC_EDGE      (`TDMP_SLOT_W + 2)
`define TDMP_RXC_PINSEL    (`TDMP_SLOT_W + 3)
`define TDMP_RXC_P21       (`TDMP_SLOT_W + 4)
`define TDMP_RXC_FRPOL     (`TDMP_SLOT_W + 5)
`define TDMP_RXC_W         (`TDMP_SLOT_W + 6)

`endif

// file: hdl/tdmp_pkg.sv
// Purpose: shared types of the serial highway pin datapath
// Assumes: tdmp_cfg.svh supplies the sizes
// Notes:   types only
`include "tdmp_cfg.svh"

package tdmp_pkg;
    typedef logic [`TDMP_BYTE_W-1:0] tdmp_byte_t;
    typedef logic [`TDMP_SLOT_W-1:0] tdmp_slot_t;
    typedef logic [3:0]              tdmp_pins_t;
endpackage

// file: hdl/tdmp_buf2.sv
// Purpose: two-entry valid/ready buffer
// Assumes: single clock, asynchronous active-low reset
// Notes:   in_ready low only when both entries are held
module tdmp_buf2 #(
    parameter int W = 8
) (
    input  wire logic         clock,
    input  wire logic         resetn,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic      [W-1:0] out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    logic [W-1:0] mem_q [2];
    logic         wr_q;
    logic         rd_q;
    logic [1:0]   cnt_q;
    wire          push = in_valid & in_ready;
    wire          pop  = out_valid & out_ready;

    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rd_q];

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            wr_q  <= wr_q ^ push;
            rd_q  <= rd_q ^ pop;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

// file: bench/tdmp_checker.sv
// Purpose: port assertions of the highway pin datapath
// Assumes: config ports static while out of reset
// Notes:   bound to tdmp_datapath below
module tdmp_checker
    import tdmp_pkg::*;
(
    input wire logic       clock,
    input wire logic       resetn,
    input wire logic       tx_serial_clock,
    input wire logic       tx_data_primary,
    input wire logic       tx_data_primary_oe,
    input wire logic       tx_data_secondary,
    input wire logic       tx_data_secondary_oe,
    input wire logic       shared_out_pin_select,
    input wire logic       primary_out_enable,
    input wire logic       secondary_out_enable,
    input wire logic       tx_clock_edge_invert,
    input wire tdmp_byte_t rx_byte,
    input wire logic       rx_byte_valid,
    input wire logic       rx_byte_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // run length of primary drive, in link edges
    // ****************************************************************
    logic [3:0] run_q;
    wire  [3:0] run_d = tx_data_primary_oe ? run_q + 4'h1 : 4'h0;
    always_ff @(posedge tx_serial_clock or negedge resetn) begin
        if (!resetn) begin
            run_q <= 4'h0;
        end else begin
            run_q <= run_d;
        end
    end
    a_slot_len_max:
    assert property (@(posedge tx_serial_clock) disable iff (!resetn) run_q <= 4'h8)
        else $error("primary drive longer than one slot");
    a_slot_len_exact:
    assert property (@(posedge tx_serial_clock) disable iff (!resetn) $fell(tx_data_primary_oe) |-> run_q == 4'h8)
        else $error("primary slot not eight bits");
    a_launch_edge:
    assert property (@(posedge clock) disable iff (!resetn)
        $changed(tx_data_primary_oe) |-> tx_serial_clock == tx_clock_edge_invert)
        else $error("primary drive changed on wrong link edge");
    a_strobe_tracks:
    assert property (@(posedge clock) disable iff (!resetn)
        shared_out_pin_select && tx_data_secondary_oe |-> tx_data_secondary == !tx_data_primary_oe)
        else $error("strobe does not match primary bit positions");
    a_strobe_held:
    assert property (@(posedge clock) disable iff (!resetn)
        shared_out_pin_select && $past(tx_data_secondary_oe) |-> tx_data_secondary_oe)
        else $error("strobe pin released");
    a_strobe_quiet:
    assert property (@(posedge clock) disable iff (!resetn)
        shared_out_pin_select && !primary_out_enable && tx_data_secondary_oe |-> tx_data_secondary)
        else $error("strobe low or data on shared pin");
    a_pri_gated:
    assert property (@(posedge clock) disable iff (!resetn) !primary_out_enable |-> !tx_data_primary_oe)
        else $error("primary driven while disabled");
    a_sec_gated:
    assert property (@(posedge clock) disable iff (!resetn)
        !shared_out_pin_select && !secondary_out_enable |-> !tx_data_secondary_oe)
        else $error("secondary driven while disabled");
    a_dual_same:
    assert property (@(posedge clock) disable iff (!resetn)
        !shared_out_pin_select && tx_data_primary_oe && tx_data_secondary_oe |-> tx_data_primary == tx_data_secondary)
        else $error("outputs carry different bits");
    a_rx_holds:
    assert property (@(posedge clock) disable iff (!resetn)
        rx_byte_valid && !rx_byte_ready |=> rx_byte_valid && $stable(rx_byte))
        else $error("received byte not held");
endmodule

bind tdmp_datapath tdmp_checker tdmp_checker_inst (.clock, .resetn, .tx_serial_clock, .tx_data_primary,
    .tx_data_primary_oe, .tx_data_secondary, .tx_data_secondary_oe, .shared_out_pin_select, .primary_out_enable,
    .secondary_out_enable, .tx_clock_edge_invert, .rx_byte, .rx_byte_valid, .rx_byte_ready);

// file: bench/tdmp_highway_model.sv
// Purpose: behavioural highway partner: link clock, frame sync, rx bits, tx capture
// Assumes: 32-bit frames, rx slot given by parameter
// Notes:   undriven tx pins read as pulled up
module tdmp_highway_model
    import tdmp_pkg::*;
#(
    parameter int FRAME   = 32,
    parameter int RX_SLOT = 1
) (
    output logic       link_clock,
    output logic       frame_sync,
    output logic       rx_data,
    input wire logic   fr_polarity,
    input wire logic   sample_on_fall,
    input wire tdmp_byte_t rx_pattern,
    input wire logic   pri,
    input wire logic   pri_oe,
    input wire logic   sec,
    input wire logic   sec_oe,
    output tdmp_byte_t got_pri,
    output tdmp_byte_t got_sec,
    output int         got_at,
    output int         n_got
);
    timeunit 1ns;
    timeprecision 100ps;
    int         cnt = 0;
    int         idx;
    int         k = 0;
    tdmp_byte_t sp;
    tdmp_byte_t ss;
    // ****************************************************************
    // free-running highway clock and frame
    // ****************************************************************
    initial begin
        link_clock = 1'b0;
        n_got = 0;
        #3;
        forever #26 link_clock = ~link_clock;
    end
    always @(posedge link_clock) begin
        cnt <= #1 (cnt == FRAME - 1) ? 0 : cnt + 1;
    end
    assign frame_sync = (cnt == FRAME - 1) ~^ fr_polarity;
    assign idx = cnt + 1 - 8 * RX_SLOT;
    assign rx_data = (idx >= 0 && idx < 8) ? rx_pattern[idx[2:0]] : cnt[0];
    // first wire bit lands in bit 0
    task automatic take();
        if (pri_oe === 1'b1) begin
            sp = {pri, sp[7:1]};
            ss = {sec_oe ? sec : 1'b1, ss[7:1]};
            k++;
        end else begin
            k = 0;
        end
        if (k == 8) begin
            got_pri = sp;
            got_sec = ss;
            got_at = cnt;
            n_got++;
            k = 0;
        end
    endtask
    always @(posedge link_clock) begin
        if (!sample_on_fall) take();
    end
    always @(negedge link_clock) begin
        if (sample_on_fall) take();
    end
endmodule

// file: bench/tb_tdmp_datapath.sv
// Purpose: self-checking bench of the highway pin datapath
// Assumes: rx in slot 1 of a 32-bit frame
// Notes:   config changes only while reset is held
`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        n_fail++; \
        $display("Error at %0t: got %h expected %h", $time, (g), (e)); \
    end \
end

module tb_tdmp_datapath
    import tdmp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, resetn, tx_serial_clock, rx_serial_clock, frame_sync, rx_data_primary;
    logic tx_data_primary, tx_data_primary_oe, tx_data_secondary, tx_data_secondary_oe;
    logic frame_sync_polarity, shared_out_pin_select, primary_out_enable, secondary_out_enable;
    logic tx_clock_edge_invert, tx_bit_invert, tx_bit_order, shared_in_pin_select, rx_pin_select;
    logic rx_bit_invert, rx_clock_edge_invert, rx_bit_order, tx_byte_valid, tx_byte_ready;
    logic rx_byte_valid, rx_byte_ready, rx_overrun, ovr_seen;
    logic [6:0] tx_slot;
    tdmp_byte_t tx_byte, rx_byte, rx_pattern, idle_x, got_pri, got_sec, p, s;
    int         n_got, got_at, n_fail = 0, total_checks = 0, cyc = 0;

    // pin 21 carries data B (inverse of A) when shared
    assign rx_serial_clock = shared_in_pin_select ? ~rx_data_primary : tx_serial_clock;
    tdmp_datapath tdmp_datapath_inst (.clock, .resetn, .tx_serial_clock, .rx_serial_clock, .frame_sync,
        .rx_data_primary, .tx_data_primary, .tx_data_primary_oe, .tx_data_secondary, .tx_data_secondary_oe,
        .frame_sync_polarity, .shared_out_pin_select, .primary_out_enable, .secondary_out_enable,
        .tx_clock_edge_invert, .tx_bit_invert, .tx_bit_order, .tx_slot, .shared_in_pin_select,
        .rx_pin_select, .rx_bit_invert, .rx_clock_edge_invert, .rx_bit_order, .rx_slot(7'h01), .tx_byte,
        .tx_byte_valid, .tx_byte_ready, .rx_byte, .rx_byte_valid, .rx_byte_ready, .rx_overrun);
    tdmp_highway_model tdmp_highway_model_inst (.link_clock(tx_serial_clock), .frame_sync,
        .rx_data(rx_data_primary), .fr_polarity(frame_sync_polarity), .sample_on_fall(tx_clock_edge_invert),
        .rx_pattern, .pri(tx_data_primary), .pri_oe(tx_data_primary_oe), .sec(tx_data_secondary),
        .sec_oe(tx_data_secondary_oe), .got_pri, .got_sec, .got_at, .n_got);

    // ****************************************************************
    // clock, watchdog, shared tasks
    // ****************************************************************
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    always @(negedge clock) begin
        if (rx_overrun === 1'b1) ovr_seen = 1'b1;
    end
    function automatic tdmp_byte_t rev8(input tdmp_byte_t b);
        for (int i = 0; i < 8; i++) rev8[i] = b[7-i];
    endfunction
    task automatic tick();
        @(posedge clock);
        #1;
    endtask
    // cfg: slot sel pe se inv ord edge fpol sin rps rinv redge rord
    task automatic setup(input logic [18:0] c, input tdmp_byte_t pat, input int hold);
        resetn = 1'b0;
        tx_byte = 8'h00;
        tx_byte_valid = 1'b0;
        rx_byte_ready = 1'b0;
        {tx_slot, shared_out_pin_select, primary_out_enable, secondary_out_enable, tx_bit_invert, tx_bit_order,
         tx_clock_edge_invert, frame_sync_polarity, shared_in_pin_select, rx_pin_select, rx_bit_invert,
         rx_clock_edge_invert, rx_bit_order} = c;
        rx_pattern = pat;
        idle_x = c[8] ? 8'h00 : 8'hFF;
        ovr_seen = 1'b0;
        repeat (hold) tick();
        resetn = 1'b1;
        tick();
    endtask
    task automatic push(input tdmp_byte_t b);
        tx_byte = b;
        tx_byte_valid = 1'b1;
        for (int i = 0; i < 2000 && tx_byte_ready !== 1'b1; i++) tick();
        tick();
        tx_byte_valid = 1'b0;
        tick();
    endtask
    task automatic get_tx();
        int n0;
        n0 = n_got;
        for (int i = 0; i < 1500; i++) begin
            tick();
            if (n_got != n0 && got_pri !== idle_x) break;
            n0 = n_got;
        end
        p = got_pri;
        s = got_sec;
    endtask
    task automatic get_rx();
        for (int i = 0; i < 1500 && rx_byte_valid !== 1'b1; i++) tick();
        p = rx_byte;
        rx_byte_ready = 1'b1;
        tick();
        rx_byte_ready = 1'b0;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_dual();
        tdmp_byte_t seq[5] = '{8'h35, 8'hC2, 8'h5A, 8'h81, 8'h3C};
        int         n = 0;
        setup(19'h01620, 8'hA6, 4);
        while (tx_byte_ready === 1'b1 && n < 5) begin
            push(seq[n]);
            n++;
        end
        `CHK(tx_byte_ready, 1'b0)
        for (int i = 0; i < n; i++) begin
            get_tx();
            `CHK(p, seq[i])
            `CHK(s, seq[i])
            `CHK(got_at, 15)
        end
        get_rx();
        `CHK(p, 8'hA6)
        for (int i = 0; i < 1500 && ovr_seen !== 1'b1; i++) tick();
        `CHK(ovr_seen, 1'b1)
        get_rx();
        `CHK(p, 8'hA6)
    endtask
    task automatic t_inv_order();
        setup(19'h025CF, 8'h1D, 4);
        push(8'h4E);
        get_tx();
        `CHK(p, ~rev8(8'h4E))
        `CHK(s, 8'hFF)
        `CHK(got_at, 23)
        get_rx();
        `CHK(p, ~rev8(8'h1D))
    endtask
    task automatic t_strobe();
        setup(19'h01E3A, 8'h93, 4);
        push(8'h6C);
        get_tx();
        `CHK(p, 8'h6C)
        `CHK(s, 8'h00)
        get_rx();
        `CHK(p, ~8'h93)
    endtask
    task automatic t_strobe_idle();
        int n0;
        setup(19'h01A20, 8'h00, 4);
        n0 = n_got;
        repeat (350) tick();
        `CHK(n_got, n0)
        `CHK(tx_data_secondary_oe, 1'b1)
        `CHK(tx_data_secondary, 1'b1)
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        setup(19'h00000, 8'h00, 16);
        t_dual();
        t_inv_order();
        t_strobe();
        t_strobe_idle();
        tally_and_finish();
    end
endmodule
